/* File: pvd_defs.svh */
`ifndef PVD_DEFS_SVH
`define PVD_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define PVD_OFS_PAGE_SELECT 8'h00
`define PVD_OFS_POWER_CONFIG 8'h75
`define PVD_OFS_CHECKSUM 8'h7E
`define PVD_OFS_DETECT_CFG_ONE 8'h1E
`define PVD_OFS_DETECT_CFG_TWO 8'h1F

// ****************************************
// pages
// ****************************************
`define PVD_PAGE_ZERO 8'h00
`define PVD_PAGE_ONE 8'h01

// ****************************************
// reset values
// ****************************************
`define PVD_RST_PAGE_SELECT 8'h00
`define PVD_RST_CHECKSUM 8'h00
`define PVD_RST_DETECT_CFG_ONE 8'h20
`define PVD_RST_DETECT_CFG_TWO 8'h08
`define PVD_RST_BIT 1'h0

// ****************************************
// field positions
// ****************************************
`define PVD_CFG1_POLICY_HI 7
`define PVD_CFG1_POLICY_LO 6
`define PVD_CFG1_CHAN_HI 5
`define PVD_CFG1_CHAN_LO 4
`define PVD_CFG1_CLK_HI 3
`define PVD_CFG1_CLK_LO 2
`define PVD_CFG1_RATE_HI 1
`define PVD_CFG1_RATE_LO 0
`define PVD_CFG2_PIN_INT 6
`define PVD_CFG2_DET_REC 3
`define PVD_CFG2_WRITE_MASK 8'hD8
`define PVD_PWR_CONV_BIT 6
`define PVD_PWR_DET_BIT 0

// ****************************************
// control bus
// ****************************************
`define PVD_BIT_LAST 3'h7
`define PVD_BIT_FIRST 3'h0
`define PVD_BYTE_ZERO 8'h00
`define PVD_ADDR_STEP 8'h01
`define PVD_DEV_ADDR_DEFAULT 7'h4C

`endif

/* File: pvd_pkg.sv */
package pvd_pkg;

	typedef enum logic [2:0] {
		PVD_ST_IDLE = 3'h0,
		PVD_ST_ADDR = 3'h1,
		PVD_ST_REG = 3'h2,
		PVD_ST_WDATA = 3'h3,
		PVD_ST_ACK = 3'h4,
		PVD_ST_RDATA = 3'h5,
		PVD_ST_RACK = 3'h6,
		PVD_ST_RLOAD = 3'h7
	} pvd_state_e;

	typedef enum logic [1:0] {
		PVD_POL_HOST = 2'h0,
		PVD_POL_DETECT_BOTH = 2'h1,
		PVD_POL_DETECT_UP = 2'h2,
		PVD_POL_DETECT_DOWN = 2'h3
	} pvd_policy_e;

	typedef enum logic [1:0] {
		PVD_CLK_INTERNAL_OSC = 2'h0,
		PVD_CLK_BIT_CLOCK = 2'h1,
		PVD_CLK_MASTER_CLOCK = 2'h2,
		PVD_CLK_CUSTOM = 2'h3
	} pvd_clk_sel_e;

	typedef enum logic [1:0] {
		PVD_RATE_3072K = 2'h0,
		PVD_RATE_6144K = 2'h1,
		PVD_RATE_12288K = 2'h2,
		PVD_RATE_18432K = 2'h3
	} pvd_rate_e;

	typedef struct packed {
		pvd_policy_e auto_power_policy;
		logic [3:0] monitored_channel_onehot;
		pvd_clk_sel_e detector_clock_select;
		pvd_rate_e external_clock_rate_select;
		logic data_pin_interrupt_enable;
		logic detect_while_recording_enable;
	} pvd_cfg_s;

	typedef struct packed {
		logic scl_in;
		logic sda_in;
	} pvd_bus_in_s;

endpackage : pvd_pkg

/* File: pvd_regs.sv */
// Contract
// - 8-bit transaction checksum readable; a host write to it loads the written byte.
// - any write to another register on any page updates the checksum.
// - 8-bit page select picks which page later accesses reach, codes 0 to 255.
// - bits 7-6 choose host or detector driven converter power-up and power-down.
// - bits 5-4 pick monitored channel 1 to 4, reset code 2.
// - bits 3-2 pick detector clock: oscillator, bit clock, master clock, custom.
// - bits 1-0 declare external detector clock rate 3.072 to 18.432 MHz.
// - pin-interrupt bit puts detector interrupt on data pin while not recording.
// - detect-while-recording bit keeps detection running during recording, reset set.
// - detector runs only while the detector enable bit is set.
// - converter power bit powers all enabled channels up when set, down when clear.
`timescale 1ns/1ps
`include "pvd_defs.svh"

module pvd_regs #(
	parameter logic [6:0] DEV_ADDR = `PVD_DEV_ADDR_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire pvd_pkg::pvd_bus_in_s bus_in,
	output logic sda_out,
	output logic sda_drive_n,
	input wire logic voice_start,
	input wire logic voice_end,
	input wire logic converter_recording,
	input wire logic detector_irq,
	input wire logic audio_data,
	output logic serial_data_out_pin,
	output logic detector_run,
	output logic converter_power_on,
	output logic [7:0] page_select,
	output pvd_pkg::pvd_cfg_s cfg
);
	import pvd_pkg::*;

	// ****************************************
	// control bus bit level
	// ****************************************
	pvd_state_e state_reg;
	pvd_state_e after_ack_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic [2:0] bit_reg;
	logic [7:0] shift_reg;
	logic [7:0] addr_reg;
	logic ack_drive_reg;
	logic master_ack_reg;

	wire scl_rise = bus_in.scl_in & ~scl_prev_reg;
	wire scl_fall = ~bus_in.scl_in & scl_prev_reg;
	wire start_cond = bus_in.scl_in & scl_prev_reg & sda_prev_reg & ~bus_in.sda_in;
	wire stop_cond = bus_in.scl_in & scl_prev_reg & ~sda_prev_reg & bus_in.sda_in;
	wire [7:0] shift_in = {shift_reg[6:0], bus_in.sda_in};
	wire byte_end = scl_rise & (bit_reg == `PVD_BIT_LAST);
	wire addr_match = shift_in[7:1] == DEV_ADDR;
	wire wr_strobe = byte_end & (state_reg == PVD_ST_WDATA);
	wire [7:0] wr_data = shift_in;
	wire ack_end = scl_fall & (state_reg == PVD_ST_ACK) & ack_drive_reg;
	wire load_rd = (ack_end & (after_ack_reg == PVD_ST_RDATA))
		| (scl_fall & (state_reg == PVD_ST_RLOAD) & master_ack_reg);
	logic [7:0] rd_data;

	// ****************************************
	// control bus state machine
	// ****************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= PVD_ST_IDLE;
			after_ack_reg <= PVD_ST_IDLE;
			scl_prev_reg <= 1'h1;
			sda_prev_reg <= 1'h1;
			bit_reg <= `PVD_BIT_FIRST;
			shift_reg <= `PVD_BYTE_ZERO;
			addr_reg <= `PVD_BYTE_ZERO;
			ack_drive_reg <= 1'h0;
			master_ack_reg <= 1'h0;
		end else begin
			scl_prev_reg <= bus_in.scl_in;
			sda_prev_reg <= bus_in.sda_in;
			if (start_cond) begin
				state_reg <= PVD_ST_ADDR;
				bit_reg <= `PVD_BIT_FIRST;
				ack_drive_reg <= 1'h0;
			end else if (stop_cond) begin
				state_reg <= PVD_ST_IDLE;
				ack_drive_reg <= 1'h0;
			end else begin
				case (state_reg)
				PVD_ST_ADDR, PVD_ST_REG, PVD_ST_WDATA: begin
					if (scl_rise) begin
						shift_reg <= shift_in;
						bit_reg <= bit_reg + 3'h1;
					end
					if (byte_end) begin
						if (state_reg == PVD_ST_ADDR) begin
							state_reg <= addr_match ? PVD_ST_ACK : PVD_ST_IDLE;
							after_ack_reg <= shift_in[0] ? PVD_ST_RDATA : PVD_ST_REG;
						end else if (state_reg == PVD_ST_REG) begin
							addr_reg <= shift_in;
							state_reg <= PVD_ST_ACK;
							after_ack_reg <= PVD_ST_WDATA;
						end else begin
							addr_reg <= addr_reg + `PVD_ADDR_STEP;
							state_reg <= PVD_ST_ACK;
							after_ack_reg <= PVD_ST_WDATA;
						end
					end
				end
				PVD_ST_ACK: begin
					if (scl_fall) begin
						ack_drive_reg <= ~ack_drive_reg;
						if (ack_drive_reg) begin
							state_reg <= after_ack_reg;
							bit_reg <= `PVD_BIT_FIRST;
						end
					end
				end
				PVD_ST_RDATA: begin
					// hold the last bit until the clock falls: letting go while high is a stop
					if (scl_rise) begin
						bit_reg <= bit_reg + 3'h1;
					end else if (scl_fall) begin
						if (bit_reg == `PVD_BIT_FIRST) begin
							state_reg <= PVD_ST_RACK;
						end else begin
							shift_reg <= {shift_reg[6:0], 1'h0};
						end
					end
				end
				PVD_ST_RACK: begin
					if (scl_rise) begin
						master_ack_reg <= ~bus_in.sda_in;
						state_reg <= PVD_ST_RLOAD;
					end
				end
				PVD_ST_RLOAD: begin
					if (scl_fall) begin
						state_reg <= master_ack_reg ? PVD_ST_RDATA : PVD_ST_IDLE;
						bit_reg <= `PVD_BIT_FIRST;
					end
				end
				default: begin
					state_reg <= PVD_ST_IDLE;
				end
				endcase
				if (load_rd) begin
					shift_reg <= rd_data;
					addr_reg <= addr_reg + `PVD_ADDR_STEP;
				end
			end
		end
	end

	// open drain: only ever pulls low
	assign sda_out = 1'h0;
	assign sda_drive_n = ~(((state_reg == PVD_ST_ACK) & ack_drive_reg)
		| ((state_reg == PVD_ST_RDATA) & ~shift_reg[7]));

	// ****************************************
	// register decode
	// ****************************************
	logic [7:0] page_reg;
	logic [7:0] checksum_reg;
	logic [7:0] cfg_one_reg;
	logic [7:0] cfg_two_reg;
	logic conv_power_reg;
	logic det_enable_reg;

	wire on_page0 = page_reg == `PVD_PAGE_ZERO;
	wire on_page1 = page_reg == `PVD_PAGE_ONE;
	wire hit_page = addr_reg == `PVD_OFS_PAGE_SELECT;
	wire hit_checksum = on_page0 & (addr_reg == `PVD_OFS_CHECKSUM);
	wire hit_power = on_page0 & (addr_reg == `PVD_OFS_POWER_CONFIG);
	wire hit_cfg_one = on_page1 & (addr_reg == `PVD_OFS_DETECT_CFG_ONE);
	wire hit_cfg_two = on_page1 & (addr_reg == `PVD_OFS_DETECT_CFG_TWO);
	wire [7:0] power_rd = {1'h0, conv_power_reg, 5'h00, det_enable_reg};
	wire [7:0] cfg_two_wr = wr_data & `PVD_CFG2_WRITE_MASK;

	assign rd_data = hit_page ? page_reg
		: hit_checksum ? checksum_reg
		: hit_power ? power_rd
		: hit_cfg_one ? cfg_one_reg
		: hit_cfg_two ? cfg_two_reg
		: `PVD_BYTE_ZERO;

	// ****************************************
	// register storage
	// ****************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			page_reg <= `PVD_RST_PAGE_SELECT;
			checksum_reg <= `PVD_RST_CHECKSUM;
			cfg_one_reg <= `PVD_RST_DETECT_CFG_ONE;
			cfg_two_reg <= `PVD_RST_DETECT_CFG_TWO;
			det_enable_reg <= `PVD_RST_BIT;
		end else if (wr_strobe) begin
			if (hit_page) begin
				page_reg <= wr_data;
			end
			if (hit_checksum) begin
				checksum_reg <= wr_data;
			end else begin
				checksum_reg <= checksum_reg + wr_data;
			end
			if (hit_cfg_one) begin
				cfg_one_reg <= wr_data;
			end
			if (hit_cfg_two) begin
				cfg_two_reg <= cfg_two_wr;
			end
			if (hit_power) begin
				det_enable_reg <= wr_data[`PVD_PWR_DET_BIT];
			end
		end
	end

	// ****************************************
	// converter power handling
	// ****************************************
	wire [1:0] policy = cfg_one_reg[`PVD_CFG1_POLICY_HI:`PVD_CFG1_POLICY_LO];
	wire det_up = (policy == PVD_POL_DETECT_BOTH) | (policy == PVD_POL_DETECT_UP);
	wire det_down = (policy == PVD_POL_DETECT_BOTH) | (policy == PVD_POL_DETECT_DOWN);
	wire host_pwr_wr = wr_strobe & hit_power;

	// detector events win over a host write in the same cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			conv_power_reg <= `PVD_RST_BIT;
		end else if (det_up & voice_start & detector_run) begin
			conv_power_reg <= 1'h1;
		end else if (det_down & voice_end & detector_run) begin
			conv_power_reg <= 1'h0;
		end else if (host_pwr_wr) begin
			conv_power_reg <= wr_data[`PVD_PWR_CONV_BIT];
		end
	end

	// ****************************************
	// detector control and data pin
	// ****************************************
	wire pin_int = cfg_two_reg[`PVD_CFG2_PIN_INT];
	wire det_rec = cfg_two_reg[`PVD_CFG2_DET_REC];
	wire pin_int_mode = pin_int & ~converter_recording;
	wire [1:0] chan = cfg_one_reg[`PVD_CFG1_CHAN_HI:`PVD_CFG1_CHAN_LO];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			serial_data_out_pin <= 1'h0;
			detector_run <= 1'h0;
		end else begin
			serial_data_out_pin <= pin_int_mode ? detector_irq : audio_data;
			detector_run <= det_enable_reg & (~converter_recording | det_rec);
		end
	end

	assign converter_power_on = conv_power_reg;
	assign page_select = page_reg;
	assign cfg.auto_power_policy = pvd_policy_e'(policy);
	assign cfg.monitored_channel_onehot = 4'h1 << chan;
	assign cfg.detector_clock_select =
		pvd_clk_sel_e'(cfg_one_reg[`PVD_CFG1_CLK_HI:`PVD_CFG1_CLK_LO]);
	assign cfg.external_clock_rate_select =
		pvd_rate_e'(cfg_one_reg[`PVD_CFG1_RATE_HI:`PVD_CFG1_RATE_LO]);
	assign cfg.data_pin_interrupt_enable = pin_int;
	assign cfg.detect_while_recording_enable = det_rec;

endmodule : pvd_regs

/* File: pvd_regs_chk.sv */
`timescale 1ns/1ps
module pvd_regs_chk (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire pvd_pkg::pvd_bus_in_s bus_in,
	input wire logic voice_start,
	input wire logic voice_end,
	input wire logic converter_recording,
	input wire logic detector_irq,
	input wire logic audio_data,
	input wire logic serial_data_out_pin,
	input wire logic detector_run,
	input wire logic converter_power_on,
	input wire logic [7:0] page_select,
	input wire pvd_pkg::pvd_cfg_s cfg
);
	import pvd_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	rst_vals_a: assert property ($rose(nrst) |-> page_select == 8'h00 && cfg == 12'h101
		&& !converter_power_on) else $error("bad state after reset");
	chan_onehot_a: assert property ($onehot(cfg.monitored_channel_onehot))
		else $error("monitored channel not one-hot");
	rec_suspend_a: assert property ($past(nrst && converter_recording
		&& !cfg.detect_while_recording_enable) |-> !detector_run) else $error("run while recording");
	pin_irq_a: assert property ($past(nrst && cfg.data_pin_interrupt_enable && !converter_recording)
		|-> serial_data_out_pin == $past(detector_irq)) else $error("data pin misses interrupt");
	pin_data_a: assert property ($past(nrst && !(cfg.data_pin_interrupt_enable && !converter_recording))
		|-> serial_data_out_pin == $past(audio_data)) else $error("data pin misses audio");
	auto_up_a: assert property ($past(nrst && voice_start && detector_run
		&& ^cfg.auto_power_policy) |-> converter_power_on) else $error("no auto power up");
	auto_down_a: assert property ($past(nrst && voice_end && detector_run && !voice_start
		&& cfg.auto_power_policy[0]) |-> !converter_power_on) else $error("no auto power down");
	write_time_a: assert property ($past(nrst) && ($changed(page_select) || $changed(cfg))
		|-> bus_in.scl_in) else $error("register changed outside a bus write");
endmodule : pvd_regs_chk

bind pvd_regs pvd_regs_chk chk_i (.sys_clk(sys_clk), .nrst(nrst), .bus_in(bus_in),
	.voice_start(voice_start), .voice_end(voice_end), .converter_recording(converter_recording),
	.detector_irq(detector_irq), .audio_data(audio_data), .serial_data_out_pin(serial_data_out_pin),
	.detector_run(detector_run), .converter_power_on(converter_power_on),
	.page_select(page_select), .cfg(cfg));

/* File: pvd_host.sv */
`timescale 1ns/1ps
module pvd_host (
	input wire logic sys_clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// lines change only at the falling edge, each phase spans whole cycles
	task automatic step(input logic c, input logic d, input int n);
		scl = c;
		sda_m = d;
		repeat (n) @(negedge sys_clk);
	endtask : step
	task automatic start();
		step(scl, 1'b1, 2);
		step(1'b1, 1'b1, 2);
		step(1'b1, 1'b0, 2);
		step(1'b0, 1'b0, 1);
	endtask : start
	task automatic stop();
		step(1'b0, 1'b0, 2);
		step(1'b1, 1'b0, 2);
		step(1'b1, 1'b1, 2);
	endtask : stop
	task automatic clk_bit(input logic d, output logic q);
		step(1'b0, d, 2);
		step(1'b1, d, 4);
		q = sda_w;
		step(1'b0, d, 1);
	endtask : clk_bit
	task automatic xbyte(input logic [7:0] d, input logic a_in, output logic [7:0] q,
		output logic a_out);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], q[i]);
		end
		clk_bit(a_in, a_out);
	endtask : xbyte
endmodule : pvd_host

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
	import pvd_pkg::*;
	localparam logic [6:0] DEV = 7'h2A;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic voice_start, voice_end, converter_recording, detector_irq, audio_data, rnd_on;
	logic scl, sda_m, sda_drive_n, sda_out, detector_run, converter_power_on, pin;
	logic [7:0] page_select, ck, pg;
	logic [31:0] r;
	pvd_cfg_s cfg;
	int seed = 32'h0BD0;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	wire sda_w = sda_m & (sda_drive_n | sda_out);
	pvd_host host (.sys_clk(sys_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
	pvd_regs #(.DEV_ADDR(DEV)) uut (.sys_clk(sys_clk), .nrst(nrst), .bus_in({scl, sda_w}),
		.sda_out(sda_out), .sda_drive_n(sda_drive_n), .voice_start(voice_start),
		.voice_end(voice_end), .converter_recording(converter_recording),
		.detector_irq(detector_irq), .audio_data(audio_data), .serial_data_out_pin(pin),
		.detector_run(detector_run), .converter_power_on(converter_power_on),
		.page_select(page_select), .cfg(cfg));
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			wrap_up();
		end
	end
	// start and end pulses never share a cycle
	always @(negedge sys_clk) begin
		r = $random(seed);
		{voice_end, voice_start} = rnd_on ? {r[1] & ~r[0] & ~voice_end, r[0] & ~voice_start} : 2'h0;
		{converter_recording, detector_irq, audio_data} = rnd_on ? r[4:2] : 3'h0;
	end
	function automatic pvd_cfg_s ecfg(input logic [7:0] a, input logic [7:0] b);
		ecfg = {a[7:6], 4'h1 << a[5:4], a[3:0], b[6], b[3]};
	endfunction : ecfg
	task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic k;
		host.start();
		host.xbyte({DEV, 1'b0}, 1'b1, q, k);
		host.xbyte(a, 1'b1, q, k);
		host.xbyte(d, 1'b1, q, k);
		host.stop();
		ck = (a == 8'h7E && pg == 8'h00) ? d : ck + d;
		if (a == 8'h00) pg = d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		logic k;
		host.start();
		host.xbyte({DEV, 1'b0}, 1'b1, q, k);
		host.xbyte(a, 1'b1, q, k);
		host.start();
		host.xbyte({DEV, 1'b1}, 1'b1, q, k);
		host.xbyte(8'hFF, 1'b1, d, k);
		host.stop();
	endtask : rd
	task automatic wrap_up();
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	initial begin
		logic [7:0] d, p, v1, v2;
		{voice_start, voice_end, converter_recording, detector_irq, audio_data, rnd_on} = 6'h00;
		{ck, pg} = 16'h0000;
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		@(negedge sys_clk);
		chk("page", page_select, 8'h00);
		chk("cfg", cfg, ecfg(8'h20, 8'h08));
		p = 8'($random(seed));
		wr(8'h7E, p);
		rd(8'h7E, d);
		chk("sum", d, p);
		repeat (4) begin
			p = 8'($random(seed));
			wr(8'h00, p);
			chk("page", page_select, p);
			rd(8'h00, d);
			chk("page read", d, p);
		end
		wr(8'h00, 8'h01);
		for (int i = 0; i < 6; i++) begin
			v1 = (i < 4) ? 8'(i * 8'h55) : 8'($random(seed));
			v2 = 8'($random(seed)) & 8'h48;
			wr(8'h1E, v1);
			wr(8'h1F, v2);
			chk("cfg", cfg, ecfg(v1, v2));
			rd(8'h1F, d);
			chk("cfg two", d, v2);
		end
		wr(8'h00, 8'h00);
		wr(8'h75, 8'h41);
		chk("power", converter_power_on, 1'b1);
		chk("run", detector_run, 1'b1);
		rnd_on = 1'b1;
		repeat (400) @(negedge sys_clk);
		rnd_on = 1'b0;
		wr(8'h75, 8'h00);
		@(negedge sys_clk);
		chk("power", converter_power_on, 1'b0);
		chk("run", detector_run, 1'b0);
		chk("pin", pin, 1'b0);
		rd(8'h7E, d);
		chk("sum", d, ck);
		wrap_up();
	end
endmodule : testbench
